// ==== srtc_pkg.sv ====
// shared constants and types for the sysref timing calibration block
package srtc_pkg;

  // register map, printed offsets
  localparam logic [11:0] ADDR_CAL_ENABLE = 12'h2B0;
  localparam logic [11:0] ADDR_CAL_CONFIG = 12'h2B1;
  localparam logic [11:0] ADDR_CAL_RESULT = 12'h2B2;

  // config field positions and reset values
  localparam int CFG_DUR_LSB = 0;
  localparam int CFG_AVG_LSB = 2;
  localparam int CFG_RSVD_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h05;
  localparam logic [7:0] ENABLE_RESET = 8'h00;

  // status field positions
  localparam int STAT_FINE_LSB = 0;
  localparam int STAT_COARSE_LSB = 8;
  localparam int STAT_INV_BIT = 16;
  localparam int STAT_DONE_BIT = 17;
  localparam logic [23:0] RESULT_RESET = 24'h000000;

  // calibration time bound factors, in sample clock cycles
  localparam int CAL_TIME_FACTOR_A = 384;
  localparam int CAL_TIME_FACTOR_B = 19;
  localparam int CAL_TIME_CYCLES = CAL_TIME_FACTOR_A * CAL_TIME_FACTOR_B;

  // longest sysref period per duration code, in sample clock cycles
  localparam logic [15:0] PERIOD_LIMIT_0 = 16'h0080;
  localparam logic [15:0] PERIOD_LIMIT_1 = 16'h0680;
  localparam logic [15:0] PERIOD_LIMIT_2 = 16'h1E80;
  localparam logic [15:0] PERIOD_LIMIT_3 = 16'h7E80;

  // configuration register layout
  typedef struct packed {
    logic [3:0] reserved;
    logic [1:0] calAverageSel;
    logic [1:0] calAccumDuration;
  } srtc_cfg_s;

  // delay setting layout
  typedef struct packed {
    logic inv;
    logic [7:0] coarse;
    logic [7:0] fine;
  } srtc_delay_s;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE, ST_FAIL} srtc_state_e;

endpackage

// ==== srtc_sysref_window.sv ====
// sysref period watch and high-speed accumulation window
`timescale 1ns/10ps
module srtc_sysref_window
  import srtc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic active,
  input wire logic sysrefLevel,
  input wire logic sysrefRise,
  input wire logic [8:0] winLen,
  input wire logic [15:0] periodLimit,
  output logic sampleValid,
  output logic [8:0] sampleValue,
  output logic periodFail
);

  logic seenEdge;
  logic [15:0] periodCnt;
  logic [8:0] winCnt;
  logic [8:0] highCnt;

  // period watch: fail once no rise arrives within the limit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seenEdge <= 1'b0;
      periodCnt <= 16'h0000;
      periodFail <= 1'b0;
    end else if (!active) begin
      seenEdge <= 1'b0;
      periodCnt <= 16'h0000;
      periodFail <= 1'b0;
    end else if (sysrefRise) begin
      seenEdge <= 1'b1;
      periodCnt <= 16'h0001;
    end else if (seenEdge && !periodFail) begin
      if (periodCnt >= periodLimit) begin
        periodFail <= 1'b1; // RULE4
      end else begin
        periodCnt <= periodCnt + 16'h0001;
      end
    end
  end

  // accumulation window: count high samples over winLen cycles from a rise
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      winCnt <= 9'h000;
      highCnt <= 9'h000;
      sampleValid <= 1'b0;
      sampleValue <= 9'h000;
    end else begin
      sampleValid <= 1'b0;
      if (!active) begin
        winCnt <= 9'h000;
        highCnt <= 9'h000;
      end else if (winCnt == 9'h000) begin
        if (sysrefRise) begin
          winCnt <= winLen - 9'h001; // RULE2
          highCnt <= 9'h001;
        end
      end else begin
        winCnt <= winCnt - 9'h001;
        highCnt <= highCnt + {8'h00, sysrefLevel};
        if (winCnt == 9'h001) begin
          sampleValid <= 1'b1;
          sampleValue <= highCnt + {8'h00, sysrefLevel};
        end
      end
    end
  end

  property p_period_fail;
    @(posedge clock) disable iff (!nrst)
    active && seenEdge && !sysrefRise && !periodFail && periodCnt >= periodLimit |=> periodFail;
  endproperty
  a_period_fail: assert property (p_period_fail) else $error("long sysref period not flagged"); // RULE4

  property p_window_sample;
    @(posedge clock) disable iff (!nrst)
    active && winCnt == 9'h000 && sysrefRise && winLen == 9'h004 ##1 active[*3] |=> sampleValid;
  endproperty
  a_window_sample: assert property (p_window_sample) else $error("four-cycle window did not close"); // RULE2

endmodule

// ==== srtc_calibration.sv ====
// sysref timing calibration: registers, sequencer and delay select
// What this block does and what it expects of software and sysref
// RULE1: averaging select at config bits 3:2, reset 1
// RULE2: accumulation duration select at config bits 1:0
// RULE3: sysref period stays within duration code limit
// RULE4: too long sysref period fails calibration
// RULE5: calibration ends within its cycle bound
// RULE6: config resets to 0x05, reserved bits zero
// RULE7: completion bit set only when enabled and done
// RULE8: status low 17 bits report delay result
// RULE9: result bit16 inversion, 15:8 coarse, 7:0 fine
// RULE10: status 24 bits, reserved zero, write ignored
// RULE11: enable rising edge starts calibration
// RULE12: disabled means manual delay drives output
// RULE13: software configures before enabling calibration
// RULE14: apply computed delay until disabled or restarted
`timescale 1ns/10ps
module srtc_calibration
  import srtc_pkg::*;
#(
  parameter int CAL_BOUND_BASE = CAL_TIME_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] regAddr,
  input wire logic regWrEn,
  input wire logic [23:0] regWrData,
  input wire logic regRdEn,
  output logic [23:0] regRdData,
  output logic regRdValid,
  input wire logic sysrefPin,
  input wire logic [16:0] manualDelay,
  output srtc_delay_s delayOut,
  output logic calComplete
);

  srtc_cfg_s cfg;
  srtc_cfg_s runCfg;
  srtc_delay_s calResult;
  srtc_state_e state;
  logic calEnable;
  logic enablePrev;
  logic calStart;
  logic sysrefMeta;
  logic sysrefSync;
  logic sysrefLast;
  logic sysrefRise;
  logic windowActive;
  logic sampleValid;
  logic [8:0] sampleValue;
  logic periodFail;
  logic [8:0] winLen;
  logic [8:0] avgTarget;
  logic [8:0] avgCnt;
  logic [16:0] avgSum;
  logic [16:0] next_avgSum;
  logic [31:0] calTimer;
  logic [31:0] timeBound;
  logic [15:0] periodLimit;
  logic [23:0] statusWord;

  // 4, 16, 64 or 256 for codes 0 to 3
  function automatic logic [8:0] countOf(input logic [1:0] code);
    countOf = 9'h004 << {code, 1'b0};
  endfunction

  // worst-case calibration length in sample clock cycles
  function automatic logic [31:0] boundOf(input logic [1:0] avg, input logic [1:0] dur);
    logic [3:0] expo;
    expo = {2'b00, avg} + {2'b00, dur} + 4'h2;
    boundOf = 32'(CAL_BOUND_BASE) << {expo, 1'b0};
  endfunction

  // average of the accumulated samples with eight fraction bits
  function automatic srtc_delay_s resultOf(input logic [16:0] sum, input logic [1:0] avg);
    logic [24:0] scaled;
    scaled = {sum, 8'h00} >> {avg, 1'b0};
    scaled = scaled >> 2;
    resultOf = srtc_delay_s'(scaled[16:0]);
  endfunction

  // longest supported sysref period per duration code
  function automatic logic [15:0] limitOf(input logic [1:0] dur);
    unique case (dur)
      2'h0: limitOf = PERIOD_LIMIT_0;
      2'h1: limitOf = PERIOD_LIMIT_1;
      2'h2: limitOf = PERIOD_LIMIT_2;
      2'h3: limitOf = PERIOD_LIMIT_3;
    endcase
  endfunction

  // settings fixed for the run that is in progress
  assign winLen = countOf(runCfg.calAccumDuration); // RULE2
  assign avgTarget = countOf(runCfg.calAverageSel); // RULE1
  assign timeBound = boundOf(runCfg.calAverageSel, runCfg.calAccumDuration);
  assign periodLimit = limitOf(runCfg.calAccumDuration);
  assign windowActive = (state == ST_RUN);
  assign calStart = calEnable && !enablePrev; // RULE11
  assign calComplete = calEnable && (state == ST_DONE); // RULE7
  assign next_avgSum = avgSum + {8'h00, sampleValue};
  assign statusWord = {6'h00, calComplete, calResult}; // RULE8 RULE9 RULE10

  // sysref pin synchroniser and rise detect
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sysrefMeta <= 1'b0;
      sysrefSync <= 1'b0;
      sysrefLast <= 1'b0;
    end else begin
      sysrefMeta <= sysrefPin;
      sysrefSync <= sysrefMeta;
      sysrefLast <= sysrefSync;
    end
  end
  assign sysrefRise = sysrefSync && !sysrefLast;

  // register writes: enable and config, status is read only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      calEnable <= ENABLE_RESET[0];
      cfg <= srtc_cfg_s'(CFG_RESET); // RULE6
    end else if (regWrEn) begin
      if (regAddr == ADDR_CAL_ENABLE) begin
        calEnable <= regWrData[0];
      end
      if (regAddr == ADDR_CAL_CONFIG) begin
        cfg.calAverageSel <= regWrData[CFG_AVG_LSB +: 2]; // RULE1
        cfg.calAccumDuration <= regWrData[CFG_DUR_LSB +: 2]; // RULE2
      end
    end
  end

  // register reads, answered one cycle later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 24'h000000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        unique case (regAddr)
          ADDR_CAL_ENABLE: regRdData <= {23'h000000, calEnable};
          ADDR_CAL_CONFIG: regRdData <= {16'h0000, 4'h0, cfg.calAverageSel, cfg.calAccumDuration}; // RULE6
          ADDR_CAL_RESULT: regRdData <= statusWord; // RULE8 RULE10
          default: regRdData <= 24'h000000;
        endcase
      end
    end
  end

  // enable history for start detect
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enablePrev <= 1'b0;
    end else begin
      enablePrev <= calEnable;
    end
  end

  // calibration sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      runCfg <= srtc_cfg_s'(CFG_RESET);
    end else if (!calEnable) begin
      state <= ST_IDLE;
    end else if (calStart) begin
      state <= ST_RUN; // RULE11
      runCfg <= cfg;
    end else begin
      unique case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_RUN: begin
          if (periodFail) begin
            state <= ST_FAIL; // RULE4
          end else if (calTimer >= timeBound - 32'h1) begin
            state <= ST_FAIL; // RULE5
          end else if (sampleValid && avgCnt == avgTarget - 9'h001) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_DONE;
        ST_FAIL: state <= ST_FAIL;
      endcase
    end
  end

  // averaging, elapsed time and result capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avgCnt <= 9'h000;
      avgSum <= 17'h00000;
      calTimer <= 32'h00000000;
      calResult <= srtc_delay_s'(RESULT_RESET[16:0]);
    end else if (calStart) begin
      avgCnt <= 9'h000;
      avgSum <= 17'h00000;
      calTimer <= 32'h00000000;
      calResult <= srtc_delay_s'(RESULT_RESET[16:0]);
    end else if (state == ST_RUN && calEnable && !periodFail) begin
      calTimer <= calTimer + 32'h00000001; // RULE5
      if (sampleValid) begin
        avgCnt <= avgCnt + 9'h001;
        avgSum <= next_avgSum;
        if (avgCnt == avgTarget - 9'h001) begin
          calResult <= resultOf(next_avgSum, runCfg.calAverageSel); // RULE9
        end
      end
    end
  end

  // delay path: manual when disabled, computed once complete
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      delayOut <= srtc_delay_s'(RESULT_RESET[16:0]);
    end else if (!calEnable) begin
      delayOut <= srtc_delay_s'(manualDelay); // RULE12
    end else if (state == ST_DONE) begin
      delayOut <= calResult; // RULE14
    end
  end

  srtc_sysref_window srtc_sysref_window_inst (
    .clock(clock),
    .nrst(nrst),
    .active(windowActive),
    .sysrefLevel(sysrefSync),
    .sysrefRise(sysrefRise),
    .winLen(winLen),
    .periodLimit(periodLimit),
    .sampleValid(sampleValid),
    .sampleValue(sampleValue),
    .periodFail(periodFail)
  );

  property p_avg_target;
    @(posedge clock) disable iff (!nrst)
    calStart |=> avgTarget == (9'h004 << {$past(cfg.calAverageSel), 1'b0});
  endproperty
  a_avg_target: assert property (p_avg_target) else $error("averaging count not taken from config"); // RULE1

  property p_win_len;
    @(posedge clock) disable iff (!nrst)
    calStart |=> winLen == (9'h004 << {$past(cfg.calAccumDuration), 1'b0});
  endproperty
  a_win_len: assert property (p_win_len) else $error("window length not taken from config"); // RULE2

  property p_fail_no_result;
    @(posedge clock) disable iff (!nrst)
    state == ST_RUN && calEnable && !calStart && periodFail |=> state == ST_FAIL ##1 !calComplete;
  endproperty
  a_fail_no_result: assert property (p_fail_no_result) else $error("failed run reported complete"); // RULE4

  property p_time_bound;
    @(posedge clock) disable iff (!nrst)
    state == ST_RUN |-> calTimer < timeBound;
  endproperty
  a_time_bound: assert property (p_time_bound) else $error("calibration exceeded its bound"); // RULE5

  property p_cfg_reset;
    @(posedge clock)
    $rose(nrst) |-> cfg == srtc_cfg_s'(CFG_RESET);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong"); // RULE6

  property p_complete;
    @(posedge clock) disable iff (!nrst)
    calComplete |-> calEnable && ($past(state) == ST_RUN || $past(calComplete));
  endproperty
  a_complete: assert property (p_complete) else $error("completion shown without finished run"); // RULE7

  property p_status_read;
    @(posedge clock) disable iff (!nrst)
    regRdEn && regAddr == ADDR_CAL_RESULT |=> regRdValid && regRdData == {6'h00, $past(calComplete), $past(calResult)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong"); // RULE8

  property p_status_write;
    @(posedge clock) disable iff (!nrst)
    regWrEn && regAddr == ADDR_CAL_RESULT && state != ST_RUN && !calStart |=> $stable(statusWord);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status changed by a write"); // RULE10

  property p_start;
    @(posedge clock) disable iff (!nrst)
    $rose(calEnable) |=> state == ST_RUN && calTimer == 32'h00000000;
  endproperty
  a_start: assert property (p_start) else $error("enable rise did not start calibration"); // RULE11

  property p_manual;
    @(posedge clock) disable iff (!nrst)
    !calEnable |=> delayOut == srtc_delay_s'($past(manualDelay));
  endproperty
  a_manual: assert property (p_manual) else $error("manual delay not driven while disabled"); // RULE12

  property p_apply;
    @(posedge clock) disable iff (!nrst)
    calComplete ##1 calComplete |-> delayOut == calResult;
  endproperty
  a_apply: assert property (p_apply) else $error("computed delay not applied"); // RULE14

endmodule

// ==== srtc_sysref_gen.sv ====
// periodic sysref source standing in for the external clock generator
`timescale 1ns/10ps
module srtc_sysref_gen (
  input wire logic clock,
  input wire logic genOn,
  input wire logic [15:0] period,
  output logic sysrefPin
);
  logic [15:0] cnt;

  // pulse train, high for all but the last 20 cycles of each period
  always_ff @(posedge clock) begin
    if (!genOn) begin
      cnt <= 16'h0000;
      sysrefPin <= 1'b0; // idle low between bursts
    end else begin
      cnt <= (cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      sysrefPin <= (cnt < period - 16'h0014);
    end
  end
endmodule

// ==== srtc_calibration_tb.sv ====
// self-checking bench for the sysref timing calibration block
`timescale 1ns/10ps
module srtc_calibration_tb;
  import srtc_pkg::*;
  // shortened bound base keeps the timeout reachable in simulation
  localparam int BASE = 64;
  typedef struct {int avg; int dur; int per; bit ok;} srtc_row_s;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic regWrEn = 1'b0;
  logic [23:0] regWrData = 24'h000000;
  logic regRdEn = 1'b0;
  logic [23:0] regRdData;
  logic regRdValid;
  logic sysrefPin;
  logic [16:0] manualDelay = 17'h1A5C3;
  srtc_delay_s delayOut;
  logic calComplete;
  logic genOn = 1'b0;
  logic [15:0] genPeriod = 16'h0064;
  int miscompares = 0;
  int nTests = 0;
  logic [23:0] rdVal;
  logic [23:0] rdOld;
  logic [16:0] expRes;
  int limitCycles;
  srtc_row_s rows[8];

  // free-running sample clock
  always #4 clock = ~clock;

  srtc_calibration #(.CAL_BOUND_BASE(BASE)) srtc_calibration_inst (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .sysrefPin(sysrefPin), .manualDelay(manualDelay),
    .delayOut(delayOut), .calComplete(calComplete)
  );

  srtc_sysref_gen srtc_sysref_gen_inst (
    .clock(clock), .genOn(genOn), .period(genPeriod), .sysrefPin(sysrefPin)
  );

  // compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask

  // one-cycle read strobe, data taken while valid stands
  task automatic rd(input logic [11:0] a, output logic [23:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1;
    chk({23'h000000, regRdValid}, 24'h000001, "read valid");
    d = regRdData;
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog against a hung calibration
  initial begin
    #480000;
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    rows = '{'{0, 0, 100, 1}, '{0, 1, 200, 1}, '{0, 2, 300, 1}, '{0, 3, 600, 1},
             '{0, 0, 200, 0}, '{2, 0, 100, 1}, '{3, 0, 100, 1}, '{1, 0, 100, 1}};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    // table of configurations, one calibration run each
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CAL_ENABLE, 24'h000000);
      genOn <= 1'b0;
      genPeriod <= 16'(rows[i].per);
      wr(ADDR_CAL_CONFIG, 24'((rows[i].avg << 2) | rows[i].dur));
      genOn <= 1'b1;
      wr(ADDR_CAL_ENABLE, 24'h000001);
      limitCycles = BASE * (4 ** (rows[i].avg + rows[i].dur + 2));
      expRes = 17'((4 << (2 * rows[i].dur)) * 256);
      for (int c = 0; c < limitCycles && calComplete !== 1'b1; c++) @(negedge clock);
      chk({23'h000000, calComplete}, 24'(rows[i].ok), "complete");
      rd(ADDR_CAL_RESULT, rdVal);
      chk(rdVal, rows[i].ok ? {6'h00, 1'b1, expRes} : 24'h000000, "status");
      if (rows[i].ok) chk({7'h00, delayOut}, {7'h00, expRes}, "applied delay");
      $display("row %0d done", i);
    end
    genOn <= 1'b0;
    // disabling drops completion and hands the path to the manual delay
    wr(ADDR_CAL_ENABLE, 24'h000000);
    @(negedge clock);
    chk({23'h000000, calComplete}, 24'h000000, "complete off");
    rd(ADDR_CAL_RESULT, rdVal);
    chk({rdVal[23:17], 17'h00000}, 24'h000000, "status done off");
    rdOld = rdVal;
    chk({7'h00, delayOut}, {7'h00, manualDelay}, "manual delay");
    $display("disable test done");
    // read-only status, reserved bits and unmapped place
    wr(ADDR_CAL_RESULT, 24'hFFFFFF);
    rd(ADDR_CAL_RESULT, rdVal);
    chk({rdVal[23:17], 17'h00000}, 24'h000000, "status write ignored");
    chk(rdVal, rdOld, "status value kept");
    wr(ADDR_CAL_CONFIG, 24'hFFFFFF);
    rd(ADDR_CAL_CONFIG, rdVal);
    chk(rdVal, 24'h00000F, "config reserved");
    rd(12'h123, rdVal);
    chk(rdVal, 24'h000000, "unmapped read");
    $display("register test done");
    // shortest duration and averaging codes for the timeout run
    wr(ADDR_CAL_CONFIG, 24'h000000);
    // no sysref during the run: the bound must end it as failed
    wr(ADDR_CAL_ENABLE, 24'h000001);
    repeat (BASE * 16 + 80) @(posedge clock);
    genOn <= 1'b1;
    repeat (600) @(posedge clock);
    chk({23'h000000, calComplete}, 24'h000000, "timed out run");
    rd(ADDR_CAL_RESULT, rdVal);
    chk(rdVal, 24'h000000, "timed out status");
    wr(ADDR_CAL_ENABLE, 24'h000000);
    $display("timeout test done");
    genOn <= 1'b1;
    wr(ADDR_CAL_ENABLE, 24'h000001);
    repeat (30) @(posedge clock);
    nrst <= 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk({7'h00, delayOut}, 24'h000000, "delay in reset");
    chk({23'h000000, calComplete}, 24'h000000, "complete in reset");
    @(posedge clock);
    genOn <= 1'b0;
    nrst <= 1'b1;
    rd(ADDR_CAL_CONFIG, rdVal);
    chk(rdVal, 24'h000005, "config reset");
    rd(ADDR_CAL_ENABLE, rdVal);
    chk(rdVal, 24'h000000, "enable reset");
    rd(ADDR_CAL_RESULT, rdVal);
    chk(rdVal, 24'h000000, "status reset");
    $display("reset test done");
    complete_run();
  end
endmodule
